// >>> src/rtc_pkg.sv
// Shared constants and types for the timekeeping core.
// Assumes byte-wide registers reached through a two-wire serial slave.
package rtc_pkg;
	// ------------------------------------------------------------------
	// Register offsets in the timekeeping block
	// ------------------------------------------------------------------
	localparam logic [7:0] REG_HUND = 8'h00;
	localparam logic [7:0] REG_SEC  = 8'h01;
	localparam logic [7:0] REG_MIN  = 8'h02;
	localparam logic [7:0] REG_HR   = 8'h03;
	localparam logic [7:0] REG_DOW  = 8'h04;
	localparam logic [7:0] REG_DATE = 8'h05;
	localparam logic [7:0] REG_MON  = 8'h06;
	localparam logic [7:0] REG_YR   = 8'h07;
	localparam logic [7:0] REG_WDF  = 8'h08;
	localparam logic [7:0] REG_WDS  = 8'h09;
	localparam logic [7:0] REG_CHG  = 8'h0a;
	localparam logic [7:0] REG_FLAG = 8'h0b;
	localparam logic [7:0] REG_CTRL = 8'h0c;
	localparam logic [7:0] PTR_ZERO = 8'h00;
	localparam logic [7:0] PTR_TOP  = 8'hff;
	// ------------------------------------------------------------------
	// Address byte: identity [7:3], block [2:1], direction [0]
	// ------------------------------------------------------------------
	localparam logic [4:0] DEV_ID    = 5'h1a; // Arbitrary value.
	localparam logic [1:0] BLK_TIME  = 2'h0;
	localparam logic [1:0] BLK_BAD   = 2'h3;
	localparam logic [3:0] BITS_BYTE = 4'h8;
	// ------------------------------------------------------------------
	// Writable bits; the rest are fixed zero
	// ------------------------------------------------------------------
	localparam logic [7:0] MSK_SEC  = 8'h7f;
	localparam logic [7:0] MSK_HR   = 8'h7f;
	localparam logic [7:0] MSK_DOW  = 8'h0f;
	localparam logic [7:0] MSK_DATE = 8'h3f;
	localparam logic [7:0] MSK_MON  = 8'h3f;
	localparam logic [7:0] MSK_CTRL = 8'h83;
	localparam int         HR_MODE  = 6;
	localparam int         HR_PM    = 5;
	localparam int         FLG_OSF  = 7;
	localparam int         FLG_WF   = 6;
	// ------------------------------------------------------------------
	// BCD counter limits
	// ------------------------------------------------------------------
	localparam logic [7:0] BCD_99      = 8'h99;
	localparam logic [7:0] BCD_59      = 8'h59;
	localparam logic [5:0] HR24_LAST   = 6'h23;
	localparam logic [4:0] HR12_ELEVEN = 5'h11;
	localparam logic [4:0] HR12_TWELVE = 5'h12;
	localparam logic [4:0] HR12_ONE    = 5'h01;
	localparam logic [2:0] DOW_LAST    = 3'h7;
	localparam logic [2:0] DOW_FIRST   = 3'h1;
	localparam logic [4:0] MON_FEB     = 5'h02;
	localparam logic [4:0] MON_APR     = 5'h04;
	localparam logic [4:0] MON_JUN     = 5'h06;
	localparam logic [4:0] MON_SEP     = 5'h09;
	localparam logic [4:0] MON_NOV     = 5'h11;
	localparam logic [4:0] MON_LAST    = 5'h12;
	localparam logic [4:0] MON_FIRST   = 5'h01;
	localparam logic [7:0] DATE_FIRST  = 8'h01;
	localparam logic [7:0] DATE_28     = 8'h28;
	localparam logic [7:0] DATE_29     = 8'h29;
	localparam logic [7:0] DATE_30     = 8'h30;
	localparam logic [7:0] DATE_31     = 8'h31;
	// ------------------------------------------------------------------
	// Oscillator dividers
	// ------------------------------------------------------------------
	localparam logic [2:0] OSC_PRE_LAST   = 3'h7;  // Divide 32.768 kHz by eight.
	localparam logic [5:0] HUND_DIV_LONG  = 6'h29; // Divide 4096 Hz by 41.
	localparam logic [5:0] HUND_DIV_SHORT = 6'h28; // Divide 4096 Hz by 40.
	localparam logic [4:0] HUND_RUN_LAST  = 5'h18; // Period 24 of 0..24 is short.
	typedef enum logic [2:0] {
		BUS_IDLE, BUS_ADDR, BUS_ACK_A, BUS_RX, BUS_ACK_W, BUS_TX, BUS_ACK_R
	} rtc_bus_e;
endpackage

// >>> src/rtc_core.sv
// Timekeeping core: hundredths generator, BCD calendar, serial slave.
// Assumes open-drain bus pins resolved outside, and an oscillator clock.
`timescale 1ns/10ps

module rtc_osc_div (
	// Oscillator clock and reset.
	input  wire logic osc_clk,
	input  wire logic rstn,
	// Tick event, as a toggle toward the core clock.
	output logic      hund_tgl
);
	import rtc_pkg::*;

	typedef struct packed {
		logic [2:0] pre;
		logic [5:0] div;
		logic [4:0] run;
		logic       tgl;
	} rtc_osc_s;

	rtc_osc_s   s;
	rtc_osc_s   n;
	logic [5:0] lim;

	// The event leaves as a toggle so the core can catch it without a handshake.
	always_comb begin
		n = s;
		lim = (s.run == HUND_RUN_LAST) ? HUND_DIV_SHORT - 6'h01 : HUND_DIV_LONG - 6'h01;
		n.pre = s.pre + 3'h1;
		if (s.pre == OSC_PRE_LAST) begin
			if (s.div == lim) begin
				n.div = 6'h00;
				n.tgl = ~s.tgl;
				n.run = (s.run == HUND_RUN_LAST) ? 5'h00 : s.run + 5'h01;
			end else begin
				n.div = s.div + 6'h01;
			end
		end
	end

	// State register.
	always_ff @(posedge osc_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign hund_tgl = s.tgl;

	property p_pre_hold;
		@(posedge osc_clk) disable iff (!rstn)
		(s.pre != OSC_PRE_LAST) |=> $stable(s.div) && $stable(s.tgl);
	endproperty
	a_pre_hold: assert property (p_pre_hold) else $error("Divider moved between prescaler wraps.");

	property p_short;
		@(posedge osc_clk) disable iff (!rstn)
		(s.pre == OSC_PRE_LAST && s.run == HUND_RUN_LAST && s.div == HUND_DIV_SHORT - 6'h01)
			|=> (s.tgl != $past(s.tgl)) && s.run == 5'h00;
	endproperty
	a_short: assert property (p_short) else $error("Short period did not end the run.");
	c_short: cover property (p_short);
endmodule

module rtc_core (
	// Clocks and reset.
	input  wire logic core_clk,
	input  wire logic osc_clk,
	input  wire logic rstn,
	// Serial bus pins.
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_n,
	// Supply supervision.
	input  wire logic power_fail_in,
	input  wire logic reset_pin_in
);
	import rtc_pkg::*;

	typedef struct packed {
		logic [2:0]      scl_sy, sda_sy, pf_sy, rp_sy, tk_sy;
		logic            scl, sda, pf, rp;
		logic [7:0]      hund, sec, min, hr, dow, date, mon, yr;
		logic [7:0]      wdf, wds, chg, ctl;
		logic            osc_stopped_flag, wf;
		logic [7:0][7:0] shadow;
		rtc_bus_e        st;
		logic [3:0]      bitc;
		logic [7:0]      sh, ptr;
		logic [1:0]      blk;
		logic            rd, first, nack, oe_n, sda_o;
	} rtc_core_s;

	rtc_core_s       s;
	rtc_core_s       n;
	logic            hund_tgl;
	logic            f_scl, f_sda, f_pf, f_rp;
	logic            tick, blocked, start, stop, rise, fall;
	logic            tw, adv, ld, snap, c_hr, nv_we;
	logic [7:0]      rb, mi;
	logic [63:0]     live;
	logic [7:0]      nvm [0:511];

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
	endfunction

	// Midnight: 23 in 24-hour mode, 11 PM in 12-hour mode.
	function automatic logic day_wrap(input logic [7:0] h);
		day_wrap = h[HR_MODE] ? (h[HR_PM] && h[4:0] == HR12_ELEVEN) : (h[5:0] == HR24_LAST);
	endfunction

	function automatic logic [7:0] hr_next(input logic [7:0] h);
		logic [7:0] t;
		t = bcd_inc({3'h0, h[4:0]});
		if (!h[HR_MODE]) begin
			t = bcd_inc({2'h0, h[5:0]});
			hr_next = (h[5:0] == HR24_LAST) ? {h[7:6], 6'h00} : {h[7:6], t[5:0]};
		end else if (h[4:0] == HR12_TWELVE) begin
			hr_next = {h[7:5], HR12_ONE};
		end else if (h[4:0] == HR12_ELEVEN) begin
			hr_next = {h[7:6], ~h[HR_PM], HR12_TWELVE};
		end else begin
			hr_next = {h[7:5], t[4:0]};
		end
	endfunction

	// Leap test on BCD year, valid through 2099.
	function automatic logic [7:0] last_date(input logic [4:0] m, input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			MON_FEB: last_date = leap ? DATE_29 : DATE_28;
			MON_APR, MON_JUN, MON_SEP, MON_NOV: last_date = DATE_30;
			default: last_date = DATE_31;
		endcase
	endfunction

	function automatic logic [7:0] ptr_next(input logic [7:0] p, input logic [1:0] b, input logic r);
		if (b == BLK_TIME) begin
			ptr_next = (p >= REG_CTRL) ? PTR_ZERO : p + 8'h01;
		end else if (!r) begin
			ptr_next = {p[7:3], p[2:0] + 3'h1};
		end else begin
			ptr_next = p + 8'h01;
		end
	endfunction

	// ------------------------------------------------------------------
	// Oscillator domain
	// ------------------------------------------------------------------
	rtc_osc_div u_osc (
		.osc_clk  (osc_clk),
		.rstn     (rstn),
		.hund_tgl (hund_tgl)
	);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		n = s;
		tw = 1'b0;
		adv = 1'b0;
		ld = 1'b0;
		snap = 1'b0;
		c_hr = 1'b0;
		nv_we = 1'b0;
		mi = bcd_inc({3'h0, s.mon[4:0]});
		live = {s.yr, s.mon, s.date, s.dow, s.hr, s.min, s.sec, s.hund};
		// Pins pass three flops; a level counts once the last two agree.
		n.scl_sy = {s.scl_sy[1:0], scl_in};
		n.sda_sy = {s.sda_sy[1:0], sda_in};
		n.pf_sy = {s.pf_sy[1:0], power_fail_in};
		n.rp_sy = {s.rp_sy[1:0], reset_pin_in};
		n.tk_sy = {s.tk_sy[1:0], hund_tgl};
		f_scl = (s.scl_sy[1] == s.scl_sy[2]) ? s.scl_sy[2] : s.scl;
		f_sda = (s.sda_sy[1] == s.sda_sy[2]) ? s.sda_sy[2] : s.sda;
		f_pf = (s.pf_sy[1] == s.pf_sy[2]) ? s.pf_sy[2] : s.pf;
		f_rp = (s.rp_sy[1] == s.rp_sy[2]) ? s.rp_sy[2] : s.rp;
		n.scl = f_scl;
		n.sda = f_sda;
		n.pf = f_pf;
		n.rp = f_rp;
		tick = s.tk_sy[1] ^ s.tk_sy[2];
		blocked = s.pf | ~s.rp;
		start = s.scl && f_scl && s.sda && !f_sda;
		stop = s.scl && f_scl && !s.sda && f_sda;
		rise = !s.scl && f_scl;
		fall = s.scl && !f_scl;

		// Read data: time bytes come from the snapshot, not the live counters.
		rb = 8'h00;
		if (s.blk != BLK_TIME) begin
			rb = nvm[{s.blk[1], s.ptr}];
		end else if (s.ptr <= REG_YR) begin
			rb = s.shadow[s.ptr[2:0]];
		end else begin
			case (s.ptr)
				REG_WDF: rb = s.wdf;
				REG_WDS: rb = s.wds;
				REG_CHG: rb = s.chg;
				REG_FLAG: rb = {s.osc_stopped_flag, s.wf, 6'h00};
				REG_CTRL: rb = s.ctl;
				default: rb = 8'h00;
			endcase
		end

		// Tick cascade; the whole carry chain settles in this one cycle.
		if (tick) begin
			n.hund = (s.hund == BCD_99) ? 8'h00 : bcd_inc(s.hund);
			if (s.hund == BCD_99) begin
				n.sec = (s.sec == BCD_59) ? 8'h00 : bcd_inc(s.sec);
				if (s.sec == BCD_59) begin
					n.min = (s.min == BCD_59) ? 8'h00 : bcd_inc(s.min);
					if (s.min == BCD_59) begin
						c_hr = 1'b1;
						n.hr = hr_next(s.hr);
						if (day_wrap(s.hr)) begin
							// Bit 3 of the weekday is spare storage and is kept.
							n.dow = (s.dow[2:0] == DOW_LAST) ? {s.dow[7:3], DOW_FIRST} :
								{s.dow[7:3], s.dow[2:0] + 3'h1};
							if (s.date == last_date(s.mon[4:0], s.yr)) begin
								n.date = DATE_FIRST;
								n.mon = (s.mon[4:0] == MON_LAST) ? {s.mon[7:5], MON_FIRST} : {s.mon[7:5], mi[4:0]};
								if (s.mon[4:0] == MON_LAST) begin
									n.yr = (s.yr == BCD_99) ? 8'h00 : bcd_inc(s.yr);
								end
							end else begin
								n.date = bcd_inc(s.date);
							end
						end
					end
				end
			end
		end

		// Serial slave; data moves after the clock falls and is sampled as it rises.
		if (blocked && s.st != BUS_IDLE) begin
			n.st = BUS_IDLE;
			n.oe_n = 1'b1;
		end else if (start) begin
			n.st = BUS_ADDR;
			n.bitc = 4'h0;
			n.oe_n = 1'b1;
			snap = 1'b1;
		end else if (stop) begin
			n.st = BUS_IDLE;
			n.oe_n = 1'b1;
		end else if (rise) begin
			case (s.st)
				BUS_ADDR, BUS_RX: begin
					n.sh = {s.sh[6:0], f_sda};
					n.bitc = s.bitc + 4'h1;
				end
				BUS_ACK_R: n.nack = f_sda;
				default: n.nack = s.nack;
			endcase
		end else if (fall) begin
			case (s.st)
				BUS_ADDR: begin
					if (s.bitc == BITS_BYTE) begin
						if (s.sh[7:3] == DEV_ID && s.sh[2:1] != BLK_BAD) begin
							n.blk = s.sh[2:1];
							n.rd = s.sh[0];
							n.first = 1'b1;
							n.oe_n = 1'b0;
							n.st = BUS_ACK_A;
						end else begin
							n.st = BUS_IDLE;
						end
					end
				end
				BUS_ACK_A: begin
					if (s.rd) begin
						ld = 1'b1;
					end else begin
						n.oe_n = 1'b1;
						n.st = BUS_RX;
						n.bitc = 4'h0;
					end
				end
				BUS_RX: begin
					if (s.bitc == BITS_BYTE) begin
						n.oe_n = 1'b0;
						n.st = BUS_ACK_W;
						n.first = 1'b0;
						if (s.first) begin
							n.ptr = s.sh;
						end else begin
							adv = 1'b1;
							nv_we = (s.blk != BLK_TIME);
							tw = (s.blk == BLK_TIME);
						end
					end
				end
				BUS_ACK_W: begin
					n.oe_n = 1'b1;
					n.st = BUS_RX;
					n.bitc = 4'h0;
				end
				BUS_TX: begin
					if (s.bitc == BITS_BYTE) begin
						n.oe_n = 1'b1;
						n.st = BUS_ACK_R;
					end else begin
						n.oe_n = s.sh[7];
						n.sh = {s.sh[6:0], 1'b0};
						n.bitc = s.bitc + 4'h1;
					end
				end
				BUS_ACK_R: begin
					if (s.nack) begin
						n.st = BUS_IDLE;
						n.oe_n = 1'b1;
					end else begin
						ld = 1'b1;
					end
				end
				default: n.st = BUS_IDLE;
			endcase
		end

		// Load a read byte and drive its first bit at once.
		if (ld) begin
			n.st = BUS_TX;
			n.oe_n = rb[7];
			n.sh = {rb[6:0], 1'b0};
			n.bitc = 4'h1;
			adv = 1'b1;
		end
		if (adv) begin
			n.ptr = ptr_next(s.ptr, s.blk, s.rd);
			snap = snap | (s.blk == BLK_TIME && n.ptr == PTR_ZERO);
		end
		if (snap) begin
			n.shadow = live;
		end

		// Register writes come last so they win over a tick in the same cycle.
		if (tw) begin
			case (s.ptr)
				REG_HUND: n.hund = s.sh;
				REG_SEC: n.sec = s.sh & MSK_SEC;
				REG_MIN: n.min = s.sh & MSK_SEC;
				REG_HR: n.hr = s.sh & MSK_HR;
				REG_DOW: n.dow = s.sh & MSK_DOW;
				REG_DATE: n.date = s.sh & MSK_DATE;
				REG_MON: n.mon = s.sh & MSK_MON;
				REG_YR: n.yr = s.sh;
				REG_WDF: n.wdf = s.sh;
				REG_WDS: n.wds = s.sh;
				REG_CHG: n.chg = s.sh;
				REG_FLAG: begin
					// Flags can only be cleared from the bus.
					n.osc_stopped_flag = s.osc_stopped_flag & s.sh[FLG_OSF];
					n.wf = s.wf & s.sh[FLG_WF];
				end
				REG_CTRL: n.ctl = s.sh & MSK_CTRL;
				default: n.ctl = s.ctl;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Power-on leaves every counter at zero; the bus lines idle high.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.scl <= 1'b1;
			s.sda <= 1'b1;
			s.pf <= 1'b1;
			// Bus synchronisers start at the idle high level, so no false edge follows reset; power fail starts set.
			s.scl_sy <= '1;
			s.sda_sy <= '1;
			s.pf_sy <= '1;
			s.oe_n <= 1'b1;
			s.osc_stopped_flag <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// Storage bytes; programming time is not modelled, a write lands at once.
	always_ff @(posedge core_clk) begin
		if (nv_we) begin
			nvm[{s.blk[1], s.ptr}] <= s.sh;
		end
	end

	assign sda_out = s.sda_o;
	assign sda_oe_n = s.oe_n;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	property p_ack; (s.st == BUS_ACK_A || s.st == BUS_ACK_W) |-> !s.oe_n; endproperty
	a_ack: assert property (p_ack) else $error("Acknowledge not driven.");
	property p_pf; (s.st == BUS_ADDR && s.pf) |=> s.st == BUS_IDLE; endproperty
	a_pf: assert property (p_pf) else $error("Access taken in power fail.");
	property p_rp; (s.st == BUS_ADDR && !s.rp) |=> s.st == BUS_IDLE; endproperty
	a_rp: assert property (p_rp) else $error("Access taken before reset release.");
	property p_twrap; (adv && s.blk == BLK_TIME && s.ptr == REG_CTRL) |=> s.ptr == PTR_ZERO && s.shadow == $past(live);
	endproperty
	a_twrap: assert property (p_twrap) else $error("Time pointer wrap or snapshot wrong.");
	property p_snap; (start && !blocked) |=> s.shadow == $past(live); endproperty
	a_snap: assert property (p_snap) else $error("No snapshot on start.");
	property p_nvrd; (adv && s.blk != BLK_TIME && s.rd && s.ptr == PTR_TOP) |=> s.ptr == PTR_ZERO && $stable(s.blk);
	endproperty
	a_nvrd: assert property (p_nvrd) else $error("Read wrap left the block.");
	property p_page; (adv && s.blk != BLK_TIME && !s.rd) |=> (s.ptr & 8'hf8) == ($past(s.ptr) & 8'hf8); endproperty
	a_page: assert property (p_page) else $error("Write left its page.");
	property p_roll; (tick && !tw && s.hund == BCD_99 && s.sec == BCD_59 && s.min == 8'h09) |=> s.min == 8'h10;
	endproperty
	a_roll: assert property (p_roll) else $error("Minute carry not in BCD.");
	property p_leap; (c_hr && !tw && !s.hr[HR_MODE] && s.hr[5:0] == HR24_LAST && s.date == DATE_28
		&& s.mon[4:0] == MON_FEB && s.yr == 8'h24) |=> s.date == DATE_29;
	endproperty
	a_leap: assert property (p_leap) else $error("Leap day skipped.");
	property p_dow; (c_hr && !tw && day_wrap(s.hr)) |=> s.dow != $past(s.dow); endproperty
	a_dow: assert property (p_dow) else $error("Weekday held at midnight.");
	property p_pm; (c_hr && !tw && s.hr[HR_MODE] && s.hr[4:0] == HR12_ELEVEN) |=> s.hr[HR_PM] != $past(s.hr[HR_PM]);
	endproperty
	a_pm: assert property (p_pm) else $error("Afternoon bit did not flip.");
	property p_zero; tw |=> !s.sec[7] && !s.hr[7] && s.ctl[6:2] == 5'h00; endproperty
	a_zero: assert property (p_zero) else $error("Fixed-zero bit set.");

	c_read: cover property (s.st == BUS_ACK_R && fall && !s.nack);
	c_write: cover property (tw);
	c_midnight: cover property (c_hr && day_wrap(s.hr));
endmodule

// >>> test/rtc_host_model.sv
// Host side of the two-wire bus: frame edges, bits and bytes.
// Assumes the bench resolves the open-drain wire and feeds it back.
`timescale 1ns/10ps
module rtc_host_model (
	// Core clock and resolved data line.
	input  wire logic       clk,
	input  wire logic       sda_w,
	// Lines driven by the host; high means released.
	output logic            scl,
	output logic            sda_m,
	// One result per acknowledge or read byte.
	output logic            res_stb,
	output logic [7:0]      res
);
	// Both lines idle released, the pull-up holds them high.
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
		res_stb = 1'b0;
		res = 8'h00;
	end
	// Eight core cycles per half period, longer than the three-cycle delay of the slave's pin filter.
	task automatic half();
		repeat (8) @(posedge clk);
	endtask
	// Hand one result to the bench for a single cycle.
	task automatic report(input logic [7:0] v);
		res <= v;
		res_stb <= 1'b1;
		@(posedge clk);
		res_stb <= 1'b0;
	endtask
	// Data moves only while the clock is low, so no false edge is seen.
	task automatic bitx(input logic b, output logic r);
		sda_m <= b;
		half();
		scl <= 1'b1;
		half();
		r = sda_w;
		scl <= 1'b0;
		half();
	endtask
	// Data falling while the clock is high opens a frame.
	task automatic start();
		sda_m <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sda_m <= 1'b0;
		half();
		scl <= 1'b0;
		half();
	endtask
	// Data rising while the clock is high closes a frame.
	task automatic stop();
		sda_m <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sda_m <= 1'b1;
		half();
	endtask
	// Most significant bit first; reports 1 when the slave acknowledged.
	task automatic send(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
		bitx(1'b1, r);
		report({7'h00, ~r});
	endtask
	// The host refuses the last byte so the slave lets go of the line.
	task automatic recv(input logic last);
		logic [7:0] d;
		logic       r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(last, r);
		report(d);
	endtask
endmodule

// >>> test/rtc_timekeeping_core_test.sv
// Self-checking bench for the timekeeping core, driven as a bus host.
// Assumes the host model in rtc_host_model and a pull-up on the data wire.
`timescale 1ns/10ps
module rtc_timekeeping_core_test;
	import rtc_pkg::*;
	logic       core_clk      = 1'b0;
	logic       osc_clk       = 1'b0;
	logic       rstn          = 1'b0;
	logic       power_fail_in = 1'b0;
	logic       reset_pin_in  = 1'b1;
	logic       scl;
	logic       sda_m;
	logic       sda_out;
	logic       sda_oe_n;
	logic       res_stb;
	logic [7:0] res;
	logic [7:0] exp_q[$];
	logic [7:0] d[$];
	logic [7:0] st[3];
	logic [55:0] tw[4] = '{56'h59592307280224, 56'h59597103300423, 56'h59592301311299, 56'h59094505150308};
	logic [55:0] te[4] = '{56'h00000001290224, 56'h00005204010523, 56'h00000002010100, 56'h00104505150308};
	int         bad_count = 0;
	int         n_tests   = 0;
	int         seed      = 32'ha78e6593;
	// The wire is low when either party pulls it.
	wire        sda_w     = sda_m & (sda_oe_n | sda_out);

	always #2.5 core_clk = ~core_clk;
	always #32 osc_clk = ~osc_clk;

	rtc_core dut_u (.core_clk(core_clk), .osc_clk(osc_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .power_fail_in(power_fail_in), .reset_pin_in(reset_pin_in));
	rtc_host_model host_u (.clk(core_clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m), .res_stb(res_stb),
		.res(res));

	// Each result from the host is matched with the oldest expectation.
	always @(posedge core_clk) begin
		if (res_stb === 1'b1) begin
			n_tests++;
			if (exp_q.size() == 0) begin
				bad_count++;
				$display("BAD t=%0t got=%h exp=none", $time, res);
			end else begin
				if (res !== exp_q[0]) begin
					bad_count++;
					$display("BAD t=%0t got=%h exp=%h", $time, res, exp_q[0]);
				end
				void'(exp_q.pop_front());
			end
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Opens a frame; exp_ack says whether the slave should answer.
	task automatic addr(input logic [1:0] blk, input logic rd, input logic exp_ack);
		host_u.start();
		exp_q.push_back({7'h00, exp_ack});
		host_u.send({DEV_ID, blk, rd});
	endtask
	// Writes the bytes in d from pointer p.
	task automatic wr(input logic [1:0] blk, input logic [7:0] p);
		addr(blk, 1'b0, 1'b1);
		exp_q.push_back(8'h01);
		host_u.send(p);
		foreach (d[i]) begin
			exp_q.push_back(8'h01);
			host_u.send(d[i]);
		end
		host_u.stop();
	endtask
	// Reads from pointer p through a repeated start; d holds the expected bytes.
	task automatic rd(input logic [1:0] blk, input logic [7:0] p);
		addr(blk, 1'b0, 1'b1);
		exp_q.push_back(8'h01);
		host_u.send(p);
		addr(blk, 1'b1, 1'b1);
		foreach (d[i]) begin
			exp_q.push_back(d[i]);
			host_u.recv(i == d.size() - 1);
		end
		host_u.stop();
	endtask
	// Unpacks seven bytes, seconds first.
	task automatic fill(input logic [55:0] v);
		d.delete();
		for (int k = 0; k < 7; k++) begin
			d.push_back(v[55 - 8 * k -: 8]);
		end
	endtask

	// A hang is cut short here and counts as a mismatch.
	initial begin
		repeat (90000) @(posedge core_clk);
		bad_count++;
		$display("BAD t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
		finish_test();
	end

	// Main sequence.
	initial begin
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (10) @(posedge core_clk);
		// Power-on state, read past the last register so the pointer wraps.
		for (int i = 0; i < 14; i++) begin
			d.push_back((i == 11) ? 8'h80 : 8'h00);
		end
		rd(BLK_TIME, REG_HUND);
		$display("test power-on values done");
		// Fixed-zero bits read zero, spare bits keep what was written.
		d = '{8'ha5, 8'hb7, 8'hd2, 8'hff, 8'hf1, 8'hf2, 8'h99, 8'h12, 8'h34, 8'ha5, 8'hff, 8'hfc};
		wr(BLK_TIME, REG_SEC);
		d = '{8'h25, 8'h37, 8'h52, 8'h0f, 8'h31, 8'h32, 8'h99, 8'h12, 8'h34, 8'ha5, 8'h80, 8'h80};
		rd(BLK_TIME, REG_SEC);
		d = '{8'h00};
		wr(BLK_TIME, REG_FLAG);
		rd(BLK_TIME, REG_FLAG);
		$display("test register bits done");
		// One tick from the last hundredth carries through the whole calendar.
		// The last case stops at the minutes, so a carry into the tens digit is seen.
		for (int c = 0; c < 4; c++) begin
			fill(tw[c]);
			wr(BLK_TIME, REG_SEC);
			d = '{BCD_99};
			// Hundredths go last, so no rollover lands on half-written time.
			wr(BLK_TIME, REG_HUND);
			repeat (4400) @(posedge core_clk);
			fill(te[c]);
			rd(BLK_TIME, REG_SEC);
		end
		$display("test calendar rollover done");
		// Access is refused while the supply is low and until the reset pin lets go.
		power_fail_in <= 1'b1;
		repeat (10) @(posedge core_clk);
		addr(BLK_TIME, 1'b0, 1'b0);
		host_u.stop();
		power_fail_in <= 1'b0;
		reset_pin_in <= 1'b0;
		repeat (10) @(posedge core_clk);
		addr(BLK_TIME, 1'b0, 1'b0);
		host_u.stop();
		reset_pin_in <= 1'b1;
		repeat (10) @(posedge core_clk);
		d = '{8'h00};
		rd(BLK_TIME, REG_FLAG);
		$display("test power fail done");
		// Storage blocks are separate, reads wrap the block, writes wrap the page.
		foreach (st[i]) begin
			st[i] = 8'($random(seed));
		end
		d = '{st[0]};
		wr(2'h1, PTR_TOP);
		d = '{st[1]};
		wr(2'h1, PTR_ZERO);
		d = '{~st[0]};
		wr(2'h2, PTR_TOP);
		d = '{st[0], st[1]};
		rd(2'h1, PTR_TOP);
		d = '{~st[0]};
		rd(2'h2, PTR_TOP);
		d = '{st[1], st[2], ~st[2]};
		wr(2'h1, 8'h0e);
		d = '{~st[2]};
		rd(2'h1, 8'h08);
		addr(BLK_BAD, 1'b0, 1'b0);
		host_u.stop();
		$display("test storage done");
		for (int i = 0; i < 100 && exp_q.size() != 0; i++) begin
			@(posedge core_clk);
		end
		if (exp_q.size() != 0) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, 8'h00, exp_q[0]);
		end
		finish_test();
	end
endmodule
